// File: verilog/dptm_ctrl.sv
// Mode control, hot-plug path, identification slave and APB registers.
`timescale 1ns/100ps
`default_nettype none
`include "dptm_defs.svh"

module dptm_ctrl
	import dptm_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave port.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// Mode pins.
	input  wire logic        main_output_enable_n,
	input  wire logic        display_channel_enable,
	input  wire logic        hotplug_invert_select,
	input  wire logic        id_enable,
	input  wire logic        hotplug_in,
	// Source-side serial bus.
	input  wire logic        i2c_scl_in,
	input  wire logic        i2c_sda_in,
	output var  logic        i2c_sda_out,
	output var  logic        i2c_sda_oe_n,
	// Analog and buffer controls.
	output var  logic        tmds_lane_out_en,
	output var  logic        main_link_in_term_cm0,
	output var  logic        display_data_channel_en,
	output var  logic        low_power,
	output var  dptm_mode_e  mode,
	output var  logic        hotplug_out
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [6:0]  pins_sync;      // Synchronised pin group.
	logic        oe_n_s;         // Output enable, active low.
	logic        display_channel_enable_s;       // Display data channel enable.
	logic        inv_s;          // Hot-plug inversion select.
	logic        id_en_s;        // Identification block enable.
	logic        hpd_s;          // Hot-plug input level.
	logic        scl_s;          // Serial clock level.
	logic        sda_s;          // Serial data level.
	logic        scl_d;          // Clock one cycle back.
	logic        sda_d;          // Data one cycle back.
	wire         scl_rise;       // Clock rising edge seen.
	wire         scl_fall;       // Clock falling edge seen.
	wire         start_cond;     // Start condition seen.
	wire         stop_cond;      // Stop condition seen.
	wire         slave_on;       // Slave may take part.
	dptm_mode_e  next_mode;      // Mode from the enable pins.
	dptm_i2c_e   state;          // Slave state.
	dptm_i2c_e   next_state;     // Next slave state.
	logic [3:0]  bit_cnt;        // Bits handled in this byte.
	dptm_byte_t  shreg;          // Shift register.
	logic        rw_bit;         // Captured direction bit.
	logic [4:0]  ptr;            // Memory read pointer.
	logic        master_ack;     // Master acknowledged last byte.
	logic        sda_low;        // Slave pulls data low.
	dptm_byte_t  id_mem [`DPTM_ID_DEPTH]; // Identification bytes.
	wire  [6:0]  addr_rx;        // Received address field.
	wire         addr_match;     // Address is ours and allowed.
	wire  [4:0]  ptr_next;       // Pointer after an acknowledge.
	wire         apb_setup;      // Access phase, first cycle.
	wire         apb_commit;     // Access phase, completing edge.
	wire         apb_is_status;  // Status register selected.
	wire         apb_is_id;      // Identification word selected.
	wire  [4:0]  apb_id_idx;     // Identification word index.
	logic [31:0] status_word;    // Assembled status value.
	logic [31:0] rd_value;       // Selected read value.

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	// True when a word-aligned byte address falls in the identification window.
	function automatic logic id_hit(input logic [7:0] a);
		id_hit = (a >= `DPTM_OFS_ID_BASE) && (a < `DPTM_OFS_ID_END)
			&& (a[1:0] == 2'b00);
	endfunction

	// Clamps a pointer so reads past the end return the last byte.
	function automatic logic [4:0] id_clamp(input logic [4:0] p);
		id_clamp = (p > `DPTM_ID_LAST) ? `DPTM_ID_LAST : p;
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	// Idle-high pins pass inverted so reset matches their idle level.
	dptm_sync
	#(
		.WIDTH(7)
	)
	u_sync
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({main_output_enable_n, display_channel_enable,
			hotplug_invert_select, id_enable, hotplug_in,
			i2c_scl_in, i2c_sda_in} ^ 7'h43),
		.sync_out (pins_sync)
	);

	assign {oe_n_s, display_channel_enable_s, inv_s, id_en_s, hpd_s, scl_s, sda_s} =
		pins_sync ^ 7'h43;

	// ------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------
	// Output enable decides the mode; channel enable only picks the
	// low-power flavour, so it never touches the lanes.
	always_comb
	begin
		if (!oe_n_s)
			next_mode = DPTM_ACTIVE;
		else if (display_channel_enable_s)
			next_mode = DPTM_LOW_POWER_DDC;
		else
			next_mode = DPTM_LOW_POWER;
	end

	// Registered controls; hot-plug is kept outside any gating.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode                    <= DPTM_LOW_POWER;
			tmds_lane_out_en        <= 1'b0;
			main_link_in_term_cm0   <= 1'b1;
			low_power               <= 1'b1;
			display_data_channel_en <= 1'b0;
			hotplug_out             <= 1'b0;
		end
		else
		begin
			mode                    <= next_mode;
			tmds_lane_out_en        <= ~oe_n_s;
			main_link_in_term_cm0   <= oe_n_s;
			low_power               <= oe_n_s;
			display_data_channel_en <= display_channel_enable_s;
			hotplug_out             <= hpd_s ^ inv_s;
		end
	end

	// ------------------------------------------------------------------
	// Serial bus conditions
	// ------------------------------------------------------------------
	// Edges are found on the synchronised levels; at 200 MHz the
	// standard-mode bus gives hundreds of samples per phase.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end
		else
		begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_rise   = scl_s & ~scl_d;
	assign scl_fall   = ~scl_s & scl_d;
	assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

	// The channel enable is assumed stable during traffic; dropping it
	// simply resets the slave to idle.
	assign slave_on   = display_channel_enable_s & id_en_s;
	assign addr_rx    = shreg[7:1];
	assign addr_match = (addr_rx == `DPTM_I2C_ADDR) && id_en_s;
	assign ptr_next   = (ptr >= `DPTM_ID_LAST) ? `DPTM_ID_LAST
		: ptr + 5'h01;

	// ------------------------------------------------------------------
	// Slave state decode
	// ------------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			DPTM_IDLE:
				next_state = DPTM_IDLE;
			DPTM_ADDR:
				// Eight bits in: ours acknowledges, others go quiet.
				if (scl_fall && bit_cnt == `DPTM_ADDR_BITS)
					next_state = addr_match ? DPTM_ADDR_ACK
						: DPTM_IDLE;
			DPTM_ADDR_ACK:
				if (scl_fall)
					next_state = rw_bit ? DPTM_RD_BYTE
						: DPTM_WR_BYTE;
			DPTM_WR_BYTE:
				if (scl_fall && bit_cnt == `DPTM_ADDR_BITS)
					next_state = DPTM_WR_ACK;
			DPTM_WR_ACK:
				if (scl_fall)
					next_state = DPTM_WR_BYTE;
			DPTM_RD_BYTE:
				if (scl_fall && bit_cnt == `DPTM_BIT_LAST)
					next_state = DPTM_RD_ACK;
			DPTM_RD_ACK:
				// A missing acknowledge ends the read; wait for stop.
				if (scl_fall)
					next_state = master_ack ? DPTM_RD_BYTE
						: DPTM_IDLE;
			default:
				next_state = DPTM_IDLE;
		endcase
		// Conditions override any bit-level progress.
		if (start_cond)
			next_state = DPTM_ADDR;
		if (stop_cond || !slave_on)
			next_state = DPTM_IDLE;
	end

	// ------------------------------------------------------------------
	// Slave datapath
	// ------------------------------------------------------------------
	// Data is sampled on clock rise and changed just after clock fall,
	// so the line is stable for the whole high phase.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state      <= DPTM_IDLE;
			bit_cnt    <= 4'h0;
			shreg      <= 8'h00;
			rw_bit     <= 1'b0;
			ptr        <= 5'h00;
			master_ack <= 1'b0;
			sda_low    <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (next_state == DPTM_IDLE || start_cond)
			begin
				// Release the line on stop, disable or new start.
				bit_cnt <= 4'h0;
				sda_low <= 1'b0;
			end
			else
			begin
				case (state)
					DPTM_ADDR, DPTM_WR_BYTE:
						if (scl_rise)
						begin
							// Shift in MSB first.
							shreg   <= {shreg[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end
						else if (scl_fall &&
							bit_cnt == `DPTM_ADDR_BITS)
						begin
							// Pull low across the ninth clock.
							sda_low <= 1'b1;
							bit_cnt <= 4'h0;
							if (state == DPTM_ADDR)
								rw_bit <= shreg[0];
							else
								ptr <= shreg[4:0];
						end
					DPTM_ADDR_ACK, DPTM_WR_ACK:
						if (scl_fall)
						begin
							// Read starts at the selected sub-address.
							shreg   <= id_mem[id_clamp(ptr)];
							sda_low <= rw_bit &&
								!id_mem[id_clamp(ptr)][7];
							bit_cnt <= 4'h0;
						end
					DPTM_RD_BYTE:
						if (scl_fall)
						begin
							if (bit_cnt == `DPTM_BIT_LAST)
								sda_low <= 1'b0;
							else
							begin
								shreg   <= {shreg[6:0], 1'b0};
								sda_low <= !shreg[6];
							end
							bit_cnt <= bit_cnt + 4'h1;
						end
					DPTM_RD_ACK:
						if (scl_rise)
						begin
							master_ack <= !sda_s;
							if (!sda_s)
								ptr <= ptr_next;
						end
						else if (scl_fall && master_ack)
						begin
							shreg   <= id_mem[id_clamp(ptr)];
							sda_low <= !id_mem[id_clamp(ptr)][7];
							bit_cnt <= 4'h0;
						end
					default:
						bit_cnt <= 4'h0;
				endcase
			end
		end
	end

	// Open-drain data: only ever drive low.
	assign i2c_sda_out  = 1'b0;
	assign i2c_sda_oe_n = ~sda_low;

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	// One wait state lets the read data come from a flop.
	assign apb_setup     = psel & penable & ~pready;
	assign apb_commit    = psel & penable & pready;
	assign apb_is_status = (paddr == `DPTM_OFS_STATUS);
	assign apb_is_id     = id_hit(paddr);
	assign apb_id_idx    = 5'((paddr - `DPTM_OFS_ID_BASE) >> 2);

	// Status shows live mode, hot-plug, busy and the read pointer.
	always_comb
	begin
		status_word = 32'h0000_0000;
		status_word[`DPTM_ST_MODE_LSB +: 2] = mode;
		status_word[`DPTM_ST_HPD]           = hotplug_out;
		status_word[`DPTM_ST_BUSY]          = (state != DPTM_IDLE);
		status_word[`DPTM_ST_PTR_LSB +: 5]  = ptr;
	end

	// Read mux; unmapped addresses read as zero.
	always_comb
	begin
		rd_value = 32'h0000_0000;
		if (apb_is_status)
			rd_value = status_word;
		else if (apb_is_id)
			rd_value = {24'h00_0000, id_mem[apb_id_idx]};
	end

	// ------------------------------------------------------------------
	// APB response
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= apb_setup;
			pslverr <= apb_setup & ~(apb_is_status | apb_is_id);
			if (apb_setup && !pwrite)
				prdata <= rd_value;
		end
	end

	// ------------------------------------------------------------------
	// Identification memory
	// ------------------------------------------------------------------
	// Software loads the bytes the slave returns; the reset value is
	// zero, so every byte reads as 00 until firmware fills the memory.
	genvar gi;
	generate
		for (gi = 0; gi < `DPTM_ID_DEPTH; gi++)
		begin : g_id
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					id_mem[gi] <= `DPTM_ID_RESET;
				else if (apb_commit && pwrite && apb_is_id &&
					apb_id_idx == 5'(gi))
					id_mem[gi] <= pwdata[7:0];
			end
		end
	endgenerate

endmodule
`default_nettype wire

// File: verilog/dptm_defs.svh
// Constants for the re-driver mode control and identification slave.
`ifndef DPTM_DEFS_SVH
`define DPTM_DEFS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define DPTM_OFS_STATUS   8'h00
`define DPTM_OFS_ID_BASE  8'h40
`define DPTM_OFS_ID_END   8'h84

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define DPTM_ST_MODE_LSB  0
`define DPTM_ST_HPD       2
`define DPTM_ST_BUSY      3
`define DPTM_ST_PTR_LSB   8

// ----------------------------------------------------------------------
// Identification memory
// ----------------------------------------------------------------------
`define DPTM_ID_DEPTH     17
`define DPTM_ID_LAST      5'h10
`define DPTM_ID_RESET     8'h00
`define DPTM_I2C_ADDR     7'h40
`define DPTM_BIT_LAST     4'h7
`define DPTM_ADDR_BITS    4'h8

`endif

// File: verilog/dptm_pkg.sv
// Types shared by the re-driver control logic.
`default_nettype none
package dptm_pkg;

	// Operating mode derived from the enable pins.
	typedef enum logic [1:0] {
		DPTM_ACTIVE,
		DPTM_LOW_POWER_DDC,
		DPTM_LOW_POWER
	} dptm_mode_e;

	// Identification slave bit-level states.
	typedef enum logic [2:0] {
		DPTM_IDLE,
		DPTM_ADDR,
		DPTM_ADDR_ACK,
		DPTM_WR_BYTE,
		DPTM_WR_ACK,
		DPTM_RD_BYTE,
		DPTM_RD_ACK
	} dptm_i2c_e;

	typedef logic [7:0] dptm_byte_t;

endpackage
`default_nettype wire

// File: verilog/dptm_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
`timescale 1ns/100ps
`default_nettype none
module dptm_sync
#(
	parameter int WIDTH = 1
)
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	// First stage; only the second stage reads it.
	logic [WIDTH-1:0] meta;

	// ------------------------------------------------------------------
	// One pair of flops per bit
	// ------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			// Both stages reset low so no pin level leaks into reset.
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					meta[i]     <= 1'b0;
					sync_out[i] <= 1'b0;
				end
				else
				begin
					meta[i]     <= async_in[i];
					sync_out[i] <= meta[i];
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// File: verification/dptm_ctrl_monitor.sv
// Checker for the re-driver control block ports.
`timescale 1ns/100ps
`default_nettype none
module dptm_ctrl_monitor
	import dptm_pkg::*;
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       main_output_enable_n,
	input wire logic       display_channel_enable,
	input wire logic       hotplug_invert_select,
	input wire logic       id_enable,
	input wire logic       hotplug_in,
	input wire logic       i2c_scl_in,
	input wire logic       i2c_sda_oe_n,
	input wire logic       tmds_lane_out_en,
	input wire logic       main_link_in_term_cm0,
	input wire logic       display_data_channel_en,
	input wire logic       low_power,
	input var  dptm_mode_e mode,
	input wire logic       hotplug_out
);
	// Pins take three edges to reach outputs, so pin checks wait until
	// every value that $past sees is from after reset.
	logic [2:0] age;
	logic       up;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			age <= 3'h0;
		else if (!up)
			age <= age + 3'h1;
	assign up = (age == 3'h7);

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	hotplug_follow_a:
	assert property (up |-> hotplug_out ==
		($past(hotplug_in, 3) ^ $past(hotplug_invert_select, 3)))
		else $error("hot-plug output wrong");
	lane_gate_a:
	assert property (up |-> tmds_lane_out_en != $past(main_output_enable_n, 3)
		&& main_link_in_term_cm0 == $past(main_output_enable_n, 3)
		&& low_power == $past(main_output_enable_n, 3))
		else $error("lane gating wrong");
	mode_pins_a:
	assert property (up |-> mode == ($past(main_output_enable_n, 3) ?
		($past(display_channel_enable, 3) ? DPTM_LOW_POWER_DDC :
		DPTM_LOW_POWER) : DPTM_ACTIVE))
		else $error("mode wrong");
	channel_en_a:
	assert property (up |-> display_data_channel_en ==
		$past(display_channel_enable, 3))
		else $error("channel enable wrong");
	slave_quiet_a:
	assert property (!id_enable [*6] |-> i2c_sda_oe_n)
		else $error("slave drives while disabled");
	sda_steady_a:
	assert property ($changed(i2c_sda_oe_n) |-> !i2c_scl_in)
		else $error("data moved with clock high");
	ack_hold_a:
	assert property ($fell(i2c_sda_oe_n) |-> ##1 !i2c_sda_oe_n [*8])
		else $error("low drive too short");
	apb_wait_a:
	assert property (psel && !penable ##1 psel && penable |->
		!pready ##1 pready ##1 !pready)
		else $error("wait state wrong");

	cover property ($fell(i2c_sda_oe_n));
	cover property (mode == DPTM_LOW_POWER_DDC);
	cover property (pready);
endmodule

bind dptm_ctrl dptm_ctrl_monitor mon_u (.*);
`default_nettype wire

// File: verification/dptm_i2c_host.sv
// Behavioural source-side serial master model.
`timescale 1ns/100ps
`default_nettype none
module dptm_i2c_host
(
	output var logic scl,
	output var logic sda,
	input  wire logic line
);
	// A 1 on sda releases the line; the pull-up then reads high.
	logic busy;
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
		busy = 1'b0;
	end
	// One 125 ns bit: data moves in the low phase, sampled at high end.
	task automatic bitx(input logic b, output logic r);
		scl = 1'b0;
		#30 sda = b;
		#32.5 scl = 1'b1;
		#62.5 r = line;
	endtask
	// Start or repeated start; the clock stands still between frames.
	task automatic start();
		if (busy)
		begin
			scl = 1'b0;
			#30 sda = 1'b1;
			#32.5 scl = 1'b1;
		end
		#62.5 sda = 1'b0;
		#62.5 scl = 1'b0;
		busy = 1'b1;
	endtask
	task automatic stop();
		scl = 1'b0;
		#30 sda = 1'b0;
		#32.5 scl = 1'b1;
		#62.5 sda = 1'b1;
		busy = 1'b0;
		#62.5;
	endtask
	// Eight bits most significant first, then the acknowledge slot.
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--)
			bitx(tx[i], rx[i]);
	endtask
endmodule
`default_nettype wire

// File: verification/dptm_ctrl_bench.sv
// Self-checking bench for the re-driver control block.
`timescale 1ns/100ps
`default_nettype none
module dptm_ctrl_bench
	import dptm_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, hotplug_in, id_enable;
	logic        main_output_enable_n, display_channel_enable;
	logic        hotplug_invert_select, hotplug_out, low_power;
	logic        i2c_scl_in, i2c_sda_in, i2c_sda_out, i2c_sda_oe_n;
	logic        tmds_lane_out_en, main_link_in_term_cm0;
	logic        display_data_channel_en, scl_m, sda_m;
	logic [4:0]  pin_out;
	dptm_mode_e  mode;
	int          checks = 0;
	int          n_mismatch = 0;

	`define CHK(a, b) \
	begin \
		checks++; \
		if ((a) !== (b)) \
		begin \
			n_mismatch++; \
			$display("[ERR] %0t got %h want %h", $time, a, b); \
		end \
	end

	always #2.5 pclk = ~pclk;
	dptm_ctrl dut_u (.*);
	dptm_i2c_host host_u (.scl(scl_m), .sda(sda_m), .line(i2c_sda_in));
	// Open-drain data line: anyone pulling low wins over the pull-up.
	assign i2c_scl_in = scl_m;
	assign i2c_sda_in = sda_m & (i2c_sda_oe_n | i2c_sda_out);
	assign pin_out = {hotplug_out, tmds_lane_out_en,
		main_link_in_term_cm0, low_power, display_data_channel_en};

	function automatic logic [7:0] pat(input int i);
		return 8'h5a ^ 8'(i);
	endfunction

	// One bus transfer; held until pready is seen, bounded by a count.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			n_mismatch++;
			$display("[ERR] %0t pready never came", $time);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		logic [31:0] r;
		logic        e;
		logic [8:0]  rx;
		logic [6:0]  x;
		dptm_mode_e  me;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{hotplug_in, hotplug_invert_select, main_output_enable_n,
			display_channel_enable, id_enable} = 5'h04;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// Every combination of the four mode pins other than id_enable, changed only while the bus is idle.
		for (int i = 0; i < 16; i++)
		begin
			@(posedge pclk);
			{hotplug_in, hotplug_invert_select, main_output_enable_n,
				display_channel_enable} <= 4'(i);
			repeat (4) @(posedge pclk);
			me = !i[1] ? DPTM_ACTIVE :
				i[0] ? DPTM_LOW_POWER_DDC : DPTM_LOW_POWER;
			x = {i[3] ^ i[2], !i[1], i[1], i[1], i[0], me};
			`CHK({pin_out, mode}, x)
			apb(1'b0, 8'h00, 32'h0, r, e);
			`CHK(r[2:0], {x[6], me})
		end
		$display("pins done");
		// Identification bytes: reset value, upper bits dropped, errors.
		for (int i = 0; i < 17; i++)
		begin
			apb(1'b0, 8'(64 + 4 * i), 32'h0, r, e);
			`CHK({e, r}, 33'h0)
			apb(1'b1, 8'(64 + 4 * i), {24'hffffff, pat(i)}, r, e);
		end
		apb(1'b0, 8'h48, 32'h0, r, e);
		`CHK(r, {24'h0, pat(2)})
		apb(1'b1, 8'h90, 32'h1, r, e);
		`CHK(e, 1'b1)
		// Status is read-only: the write neither errs nor sticks.
		apb(1'b1, 8'h00, 32'hffff_ffff, r, e);
		`CHK(e, 1'b0)
		apb(1'b0, 8'h00, 32'h0, r, e);
		`CHK({e, r}, 33'h0_0000_0001)
		apb(1'b0, 8'h90, 32'h0, r, e);
		`CHK({e, r}, {1'b1, 32'h0})
		$display("registers done");
		// Refused: foreign address, slave pin low, channel low.
		for (int k = 0; k < 3; k++)
		begin
			@(posedge pclk);
			id_enable <= (k != 1);
			display_channel_enable <= (k != 2);
			repeat (4) @(posedge pclk);
			host_u.start();
			host_u.xfer({k == 0 ? 8'h82 : 8'h80, 1'b1}, rx);
			`CHK(rx[0], 1'b1)
			host_u.stop();
		end
		@(posedge pclk);
		{id_enable, display_channel_enable} <= 2'h3;
		repeat (4) @(posedge pclk);
		// Pointer write, restart, read past the end with saturation.
		host_u.start();
		host_u.xfer({8'h80, 1'b1}, rx);
		`CHK(rx[0], 1'b0)
		host_u.xfer({8'h0e, 1'b1}, rx);
		`CHK(rx[0], 1'b0)
		host_u.start();
		host_u.xfer({8'h81, 1'b1}, rx);
		`CHK(rx[0], 1'b0)
		for (int i = 0; i < 4; i++)
		begin
			host_u.xfer({8'hff, 1'(i == 3)}, rx);
			`CHK(rx[8:1], pat(i < 3 ? 14 + i : 16))
		end
		host_u.stop();
		`CHK(i2c_sda_out, 1'b0)
		// Idle again, pointer stuck at the last location, low power with the channel on.
		apb(1'b0, 8'h00, 32'h0, r, e);
		`CHK(r, 32'h0000_1001)
		$display("link done");
		conclude();
	end

	// The tests need about 15 us; nearly seven times that is taken as a hang.
	initial
	begin
		#100000;
		n_mismatch++;
		conclude();
	end
endmodule
`default_nettype wire
